// *** include/edma_pkg.sv ***
package edma_pkg;

  // ****************************************
  // Sizes and control field positions
  // ****************************************
  localparam int          NCH          = 8;
  localparam int          CON_ON_BIT   = 15;
  localparam int          CON_BYTE_BIT = 14;
  localparam int          CON_DIR_BIT  = 13;
  localparam int          CON_HALF_BIT = 12;
  localparam int          CON_NULL_BIT = 11;
  localparam int          ADDRESSING_SELECT_HI     = 5;
  localparam int          ADDRESSING_SELECT_LO     = 4;
  localparam int          MODE_PP_BIT  = 1;
  localparam int          MODE_OS_BIT  = 0;
  localparam int          REQ_FORCE    = 15;
  localparam logic [15:0] CON_MASK     = 16'hF833;
  localparam logic [15:0] ZERO16       = 16'h0000;
  localparam logic [15:0] BYTE_MASK    = 16'h00FF;
  localparam logic [15:0] STEP_BYTE    = 16'h0001;
  localparam logic [15:0] STEP_WORD    = 16'h0002;
  localparam logic [9:0]  CNT_ONE      = 10'h001;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [4:0]  REG_CON      = 5'h00;
  localparam logic [4:0]  REG_REQ      = 5'h04;
  localparam logic [4:0]  REG_STA      = 5'h08;
  localparam logic [4:0]  REG_STB      = 5'h0C;
  localparam logic [4:0]  REG_PAD      = 5'h10;
  localparam logic [4:0]  REG_CNT      = 5'h14;
  localparam logic [11:0] ADDR_CLASH   = 12'h100;
  localparam logic [11:0] ADDR_STATUS  = 12'h104;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {S_IDLE, S_READ, S_WRITE, S_DONE} edma_state_t;

  // One transaction bus port (RAM side or peripheral side)
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic        byte_sel;
    logic [15:0] addr;
    logic [15:0] wdata;
  } edma_bus_t;

  // Processor write seen on the other port of the same space
  typedef struct packed {
    logic        wr;
    logic [15:0] addr;
  } edma_snoop_t;

endpackage

// *** sim/edma_far_end.sv ***
module edma_far_end
  import edma_pkg::*;
(
  // Clock
  input  wire logic   clk,
  // Peripheral side
  input  edma_bus_t   sfr_bus,
  output logic [15:0] sfr_rdata,
  // Buffer RAM side
  input  edma_bus_t   ram_bus,
  output logic [15:0] ram_rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [15:0] sfr_q [512];
  logic [15:0] ram_q [512];

  // Known contents so that every copy can be traced
  initial begin
    for (int i = 0; i < 512; i++) begin
      sfr_q[i] = 16'h5000 + 16'(i);
      ram_q[i] = 16'hA000 + 16'(i);
    end
  end

  // Peripheral registers: data the cycle after a read, else a changing pattern
  always @(posedge clk) begin
    if (sfr_bus.wr === 1'b1) sfr_q[sfr_bus.addr[9:1]] <= sfr_bus.wdata;
    sfr_rdata <= (sfr_bus.rd === 1'b1) ? sfr_q[sfr_bus.addr[9:1]] : ~sfr_rdata;
  end

  // Buffer RAM: all buffers live here
  always @(posedge clk) begin
    if (ram_bus.wr === 1'b1) ram_q[ram_bus.addr[9:1]] <= ram_bus.wdata;
    ram_rdata <= (ram_bus.rd === 1'b1) ? ram_q[ram_bus.addr[9:1]] : ~ram_rdata;
  end
endmodule // edma_far_end

// *** sim/tb_edma_top.sv ***
module tb_edma_top
  import edma_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic             clk, nrst, psel, penable, pwrite, pready, pslverr, perr;
  logic [11:0]      paddr;
  logic [31:0]      pwdata, prdata, q;
  logic [127:0]     dma_req_in;
  logic [15:0]      periph_ram_addr, sfr_rdata, ram_rdata, ia;
  edma_bus_t        sfr_bus, ram_bus;
  edma_snoop_t      cpu_sfr_snoop, cpu_ram_snoop;
  logic [NCH-1:0]   chan_irq;
  int               miscompares, checks, cycles, nulls;
  int               irq_cnt [NCH];
  logic [15:0]      wq [$];

  edma_top i_dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .dma_req_in(dma_req_in), .periph_ram_addr(periph_ram_addr), .sfr_bus(sfr_bus),
    .sfr_rdata(sfr_rdata), .cpu_sfr_snoop(cpu_sfr_snoop), .ram_bus(ram_bus),
    .ram_rdata(ram_rdata), .cpu_ram_snoop(cpu_ram_snoop), .chan_irq(chan_irq));

  edma_far_end i_far (.clk(clk), .sfr_bus(sfr_bus), .sfr_rdata(sfr_rdata),
    .ram_bus(ram_bus), .ram_rdata(ram_rdata));

  // ****************************************
  // Clock, timeout and bus monitors
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Count cycles, interrupts, RAM writes and blank peripheral writes
  always @(posedge clk) begin
    cycles++;
    if (cycles > 20000) begin
      miscompares++;
      results();
    end
    for (int i = 0; i < NCH; i++) if (chan_irq[i] === 1'b1) irq_cnt[i]++;
    if (ram_bus.wr === 1'b1) wq.push_back(ram_bus.addr);
    if (sfr_bus.wr === 1'b1 && sfr_bus.wdata === ZERO16) nulls++;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic results();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  // One APB transfer; holds the request until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {16'h0000, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    perr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [15:0] e, input string n);
    apb(1'b0, a, ZERO16);
    chk(n, {16'h0000, e}, q);
  endtask

  function automatic logic [11:0] ra(input logic [2:0] c, input logic [4:0] r);
    return {4'h0, c, r};
  endfunction

  // Address registers first, enable last, so the channel is off while they change
  task automatic cfg(input logic [2:0] c, input logic [15:0] con, req, first_buffer_base, stb, pad, cnt);
    wr(ra(c, REG_REQ), req);
    wr(ra(c, REG_STA), first_buffer_base);
    wr(ra(c, REG_STB), stb);
    wr(ra(c, REG_PAD), pad);
    wr(ra(c, REG_CNT), cnt);
    wr(ra(c, REG_CON), con);
  endtask

  // k one-cycle pulses on request line n, spaced wider than one transfer
  task automatic pulse(input int n, input int k);
    repeat (k) begin
      @(posedge clk);
      dma_req_in[n] <= 1'b1;
      @(posedge clk);
      dma_req_in[n] <= 1'b0;
      repeat (8) @(posedge clk);
    end
  endtask

  // Manual transfer, then poll until hardware drops the force bit
  task automatic force_one(input logic [2:0] c);
    wr(ra(c, REG_REQ), 16'h8000);
    for (int i = 0; i < 20; i++) begin
      apb(1'b0, ra(c, REG_REQ), ZERO16);
      if (q[15] === 1'b0) break;
    end
    chk("force bit", 32'h0, q);
  endtask

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    {psel, penable, pwrite, paddr, pwdata, dma_req_in, periph_ram_addr} = '0;
    cpu_sfr_snoop = '0;
    cpu_ram_snoop = '0;
    nrst = 1'b0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    rd(ra(3'd0, REG_CON), ZERO16, "con reset");
    rd(ra(3'd7, REG_CNT), ZERO16, "cnt reset");
    rd(ADDR_STATUS, ZERO16, "status reset");
    apb(1'b0, 12'h0F8, ZERO16);
    chk("slverr", 32'h1, {31'h0, perr});
    $display("test reset done");
    cfg(3'd1, 16'hA001, 16'h000B, 16'h0010, ZERO16, 16'h0040, 16'h0002);
    pulse(11, 1);
    rd(ra(3'd1, REG_STA), 16'h0012, "live pointer");
    pulse(11, 2);
    chk("ram to sfr", 32'hA00A, {16'h0, i_far.sfr_q[9'h020]});
    chk("irq ch1", 32'd1, irq_cnt[1]);
    rd(ra(3'd1, REG_CON), 16'h2001, "one shot off");
    $display("test word copy done");
    cfg(3'd2, 16'hC811, ZERO16, 16'h0030, ZERO16, 16'h0020, 16'h0001);
    force_one(3'd2);
    chk("byte data", 32'h0010, {16'h0, i_far.ram_q[9'h018]});
    chk("blank data", 32'h0, {16'h0, i_far.sfr_q[9'h010]});
    rd(ra(3'd2, REG_STA), 16'h0030, "fixed pointer");
    force_one(3'd2);
    repeat (8) @(posedge clk);
    chk("blank writes", 32'd2, nulls);
    chk("irq ch2", 32'd1, irq_cnt[2]);
    $display("test byte copy done");
    cfg(3'd3, 16'h8001, 16'h0005, 16'h0060, ZERO16, 16'h0002, ZERO16);
    cfg(3'd4, 16'h8001, 16'h0005, 16'h0070, ZERO16, 16'h0002, ZERO16);
    wq.delete();
    pulse(5, 1);
    repeat (8) @(posedge clk);
    chk("first grant", 32'h0060, {16'h0, wq[0]});
    chk("second grant", 32'h0070, {16'h0, wq[1]});
    $display("test priority done");
    cfg(3'd0, 16'h9002, 16'h0001, 16'h0100, 16'h0180, 16'h0004, 16'h0003);
    wq.delete();
    pulse(1, 8);
    chk("half irq", 32'd2, irq_cnt[0]);
    chk("block a end", 32'h0106, {16'h0, wq[3]});
    chk("block b start", 32'h0180, {16'h0, wq[4]});
    rd(ra(3'd0, REG_CON), 16'h9002, "continuous on");
    wr(ra(3'd0, REG_CON), ZERO16);
    $display("test ping pong done");
    for (int m = 2; m < 4; m++) begin
      ia = 16'h0080 + 16'(4 * m);
      periph_ram_addr <= ia;
      cfg(3'd5, 16'h8001 | 16'(m * 16), ZERO16, ZERO16, ZERO16, 16'h0002, ZERO16);
      wq.delete();
      force_one(3'd5);
      chk("indirect addr", {16'h0, ia}, {16'h0, wq[0]});
      chk("indirect data", 32'h5001, {16'h0, i_far.ram_q[ia[9:1]]});
    end
    $display("test indirect done");
    cfg(3'd6, 16'h8801, ZERO16, 16'h00A0, ZERO16, 16'h0002, ZERO16);
    cpu_ram_snoop <= '{wr: 1'b1, addr: 16'h00A0};
    cpu_sfr_snoop <= '{wr: 1'b1, addr: 16'h0002};
    force_one(3'd6);
    cpu_ram_snoop <= '0;
    cpu_sfr_snoop <= '0;
    rd(ADDR_CLASH, 16'h4040, "ram and sfr clash");
    wr(ADDR_CLASH, 16'hFFFF);
    rd(ADDR_CLASH, ZERO16, "clash cleared");
    $display("test collision done");
    cfg(3'd7, 16'h2001, 16'h007F, 16'h0020, ZERO16, 16'h0006, ZERO16);
    pulse(127, 1);
    chk("off dropped", 32'd0, irq_cnt[7]);
    wr(ra(3'd7, REG_CON), 16'hA001);
    pulse(127, 1);
    chk("source 127", 32'd1, irq_cnt[7]);
    chk("source data", 32'hA010, {16'h0, i_far.sfr_q[9'h003]});
    $display("test request select done");
    results();
  end
endmodule // tb_edma_top

// *** verilog/edma_top.sv ***
// Functional notes
// - Eight channels, each with control, select, two bases, target and 10-bit tally.
// - Control bit 13 picks RAM-to-peripheral or peripheral-to-RAM.
// - Control bit 14 set means byte transfers, clear means words.
// - Interrupt at block end, or at half block when control bit 12 set.
// - Bit 11 adds a zero write to the peripheral; only for peripheral-to-RAM.
// - Addressing values 10 and 11 take the RAM address from the peripheral.
// - Addressing 00 steps the RAM address, 01 keeps it fixed.
// - Mode values 01 and 11 are one-shot, 00 and 10 repeat blocks.
// - Modes 11 and 10 alternate between the two buffer bases per block; here mode 11 turns off after the first block, so only the first base is used.
// - Force bit starts one manual transfer; hardware alone clears it afterwards.
// - A 7-bit select picks one of 128 request lines as trigger.
// - Request numbers map to fixed peripheral events and register addresses.
// - Base registers read back the live pointer; writes store the base.
// - Transfers use their own buses, never stealing processor cycles.
// - Simultaneous requests are arbitrated by fixed priority.
// - Two shared status registers: clash flags, and activity plus buffer state.
// - A block is the programmed tally plus one transfers.
// - Hardware sets a clash flag; software can clear but not set it.
//
// Our own choices: the APB register port and the register offsets.
module edma_top
  import edma_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Peripheral request lines and indirect RAM address
  input  wire logic [127:0] dma_req_in,
  input  wire logic [15:0]  periph_ram_addr,
  // Peripheral transaction bus
  output edma_bus_t        sfr_bus,
  input  wire logic [15:0] sfr_rdata,
  input  edma_snoop_t      cpu_sfr_snoop,
  // Buffer RAM transaction bus
  output edma_bus_t        ram_bus,
  input  wire logic [15:0] ram_rdata,
  input  edma_snoop_t      cpu_ram_snoop,
  // Per-channel interrupt requests
  output logic [NCH-1:0]   chan_irq
);

  // ****************************************
  // Storage
  // ****************************************
  logic [15:0]    con_q   [NCH];
  logic [6:0]     sel_q   [NCH];
  logic [15:0]    sta_q   [NCH];
  logic [15:0]    stb_q   [NCH];
  logic [15:0]    pad_q   [NCH];
  logic [15:0]    ptr_q   [NCH];
  logic [9:0]     cnt_q   [NCH];
  logic [9:0]     tally_q [NCH];
  logic [NCH-1:0] force_q;
  logic [NCH-1:0] pend_q;
  logic [NCH-1:0] buf_q;
  logic [NCH-1:0] xclash_q;
  logic [NCH-1:0] pclash_q;
  edma_state_t    state_q;
  logic [2:0]     gch_q;
  logic           gforce_q;
  logic [15:0]    raddr_q;

  // ****************************************
  // APB decode
  // ****************************************
  logic        is_chan;
  logic        hit;
  logic [2:0]  ch_idx;
  logic [4:0]  reg_idx;
  logic        acc;
  logic        wr_acc;
  logic [15:0] rd_mux;
  logic [NCH-1:0] busy_oh;

  // Address decode, held stable by the master through the access phase
  always_comb begin
    ch_idx  = paddr[7:5];
    reg_idx = paddr[4:0];
    is_chan = (paddr[11:8] == 4'h0) && (reg_idx <= REG_CNT) && (reg_idx[1:0] == 2'h0);
    hit     = is_chan || (paddr == ADDR_CLASH) || (paddr == ADDR_STATUS);
    acc     = psel && penable && pready;
    wr_acc  = acc && pwrite && !pslverr;
  end

  // Activity view: pending or in flight
  always_comb begin
    busy_oh = pend_q;
    if (state_q != S_IDLE) begin
      busy_oh[gch_q] = 1'b1;
    end
  end

  // Read data; base registers show the live pointer
  always_comb begin
    rd_mux = ZERO16;
    if (paddr == ADDR_CLASH) begin
      rd_mux = {pclash_q, xclash_q};
    end else if (paddr == ADDR_STATUS) begin
      rd_mux = {buf_q, busy_oh};
    end else if (is_chan) begin
      case (reg_idx)
        REG_CON: rd_mux = con_q[ch_idx];
        REG_REQ: rd_mux = {force_q[ch_idx], 8'h00, sel_q[ch_idx]};
        REG_STA: rd_mux = ptr_q[ch_idx];
        REG_STB: rd_mux = ptr_q[ch_idx];
        REG_PAD: rd_mux = pad_q[ch_idx];
        REG_CNT: rd_mux = {6'h00, cnt_q[ch_idx]};
        default: rd_mux = ZERO16;
      endcase
    end
  end

  // Zero-wait slave: ready and data in the first access cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      prdata  <= {16'h0000, rd_mux};
      pslverr <= psel && !penable && !hit;
    end
  end

  // ****************************************
  // Arbitration
  // ****************************************
  logic [2:0]     low_ch;
  logic [NCH-1:0] grant_oh;
  logic [NCH-1:0] done_oh;

  // Lowest-numbered pending channel wins
  always_comb begin
    low_ch = 3'h0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (pend_q[i]) begin
        low_ch = 3'(i);
      end
    end
    grant_oh = '0;
    done_oh  = '0;
    if (state_q == S_IDLE && pend_q != '0) begin
      grant_oh[low_ch] = 1'b1;
    end
    if (state_q == S_DONE) begin
      done_oh[gch_q] = 1'b1;
    end
  end

  // ****************************************
  // Channel logic
  // ****************************************
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    logic wsel;
    logic start;
    logic last;
    logic half;
    logic force_set;
    logic [15:0] step;

    always_comb begin
      wsel      = wr_acc && is_chan && (ch_idx == 3'(c));
      start     = wsel && (reg_idx == REG_CON) && pwdata[CON_ON_BIT] && !con_q[c][CON_ON_BIT];
      force_set = wsel && (reg_idx == REG_REQ) && pwdata[REQ_FORCE];
      last      = (tally_q[c] == cnt_q[c]);
      half      = (tally_q[c] == {1'b0, cnt_q[c][9:1]});
      step      = con_q[c][CON_BYTE_BIT] ? STEP_BYTE : STEP_WORD;
    end

    // Control word; one-shot block end turns the channel off
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        con_q[c] <= ZERO16;
      end else if (wsel && reg_idx == REG_CON) begin
        con_q[c] <= pwdata[15:0] & CON_MASK;
      end else if (done_oh[c] && last && con_q[c][MODE_OS_BIT]) begin
        con_q[c][CON_ON_BIT] <= 1'b0;
      end
    end

    // Plain configuration registers
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        sel_q[c] <= 7'h00;
        sta_q[c] <= ZERO16;
        stb_q[c] <= ZERO16;
        pad_q[c] <= ZERO16;
        cnt_q[c] <= 10'h000;
      end else if (wsel) begin
        if (reg_idx == REG_REQ) sel_q[c] <= pwdata[6:0];
        if (reg_idx == REG_STA) sta_q[c] <= pwdata[15:0];
        if (reg_idx == REG_STB) stb_q[c] <= pwdata[15:0];
        if (reg_idx == REG_PAD) pad_q[c] <= pwdata[15:0];
        if (reg_idx == REG_CNT) cnt_q[c] <= pwdata[9:0];
      end
    end

    // Force bit: software sets only, forced transfer end clears, set wins
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        force_q[c] <= 1'b0;
      end else if (force_set) begin
        force_q[c] <= 1'b1;
      end else if (done_oh[c] && gforce_q) begin
        force_q[c] <= 1'b0;
      end
    end

    // Pending request from the selected line or a force, set wins over grant
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        pend_q[c] <= 1'b0;
      end else if (con_q[c][CON_ON_BIT] && (dma_req_in[sel_q[c]] || force_set)) begin
        pend_q[c] <= 1'b1;
      end else if (grant_oh[c]) begin
        pend_q[c] <= 1'b0;
      end
    end

    // Live pointer, tally and ping-pong buffer state
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        ptr_q[c]   <= ZERO16;
        tally_q[c] <= 10'h000;
        buf_q[c]   <= 1'b0;
      end else if (start) begin
        ptr_q[c]   <= sta_q[c];
        tally_q[c] <= 10'h000;
        buf_q[c]   <= 1'b0;
      end else if (done_oh[c]) begin
        if (last) begin
          tally_q[c] <= 10'h000;
          if (con_q[c][MODE_PP_BIT]) begin
            buf_q[c] <= !buf_q[c];
            ptr_q[c] <= buf_q[c] ? sta_q[c] : stb_q[c];
          end else begin
            ptr_q[c] <= buf_q[c] ? stb_q[c] : sta_q[c];
          end
        end else begin
          tally_q[c] <= tally_q[c] + CNT_ONE;
          if (con_q[c][ADDRESSING_SELECT_HI:ADDRESSING_SELECT_LO] == 2'b00) begin
            ptr_q[c] <= ptr_q[c] + step;
          end
        end
      end
    end

    // Interrupt pulse at full or half block
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        chan_irq[c] <= 1'b0;
      end else begin
        chan_irq[c] <= done_oh[c] && (con_q[c][CON_HALF_BIT] ? half : last);
      end
    end

    // Clash flags: hardware sets, write-one clears, set wins
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        xclash_q[c] <= 1'b0;
        pclash_q[c] <= 1'b0;
      end else begin
        if (done_oh[c] && ram_bus.wr && cpu_ram_snoop.wr && cpu_ram_snoop.addr == ram_bus.addr) begin
          xclash_q[c] <= 1'b1;
        end else if (wr_acc && paddr == ADDR_CLASH && pwdata[c]) begin
          xclash_q[c] <= 1'b0;
        end
        if (done_oh[c] && sfr_bus.wr && cpu_sfr_snoop.wr && cpu_sfr_snoop.addr == sfr_bus.addr) begin
          pclash_q[c] <= 1'b1;
        end else if (wr_acc && paddr == ADDR_CLASH && pwdata[c + 8]) begin
          pclash_q[c] <= 1'b0;
        end
      end
    end
  end

  // ****************************************
  // Transfer engine on the private buses
  // ****************************************
  logic [15:0] g_con;
  logic [15:0] rd_word;

  always_comb begin
    g_con   = con_q[gch_q];
    rd_word = g_con[CON_DIR_BIT] ? ram_rdata : sfr_rdata;
    if (g_con[CON_BYTE_BIT]) begin
      rd_word = rd_word & BYTE_MASK;
    end
  end

  // Idle, read strobe, write strobe, bookkeeping; four cycles per transfer
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q  <= S_IDLE;
      gch_q    <= 3'h0;
      gforce_q <= 1'b0;
      raddr_q  <= ZERO16;
      ram_bus  <= '0;
      sfr_bus  <= '0;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (pend_q != '0) begin
            gch_q    <= low_ch;
            gforce_q <= force_q[low_ch];
            raddr_q  <= con_q[low_ch][ADDRESSING_SELECT_HI] ? periph_ram_addr : ptr_q[low_ch];
            ram_bus.byte_sel <= con_q[low_ch][CON_BYTE_BIT];
            sfr_bus.byte_sel <= con_q[low_ch][CON_BYTE_BIT];
            if (con_q[low_ch][CON_DIR_BIT]) begin
              ram_bus.rd   <= 1'b1;
              ram_bus.addr <= con_q[low_ch][ADDRESSING_SELECT_HI] ? periph_ram_addr : ptr_q[low_ch];
            end else begin
              sfr_bus.rd   <= 1'b1;
              sfr_bus.addr <= pad_q[low_ch];
            end
            state_q <= S_READ;
          end
        end
        S_READ: begin
          ram_bus.rd <= 1'b0;
          sfr_bus.rd <= 1'b0;
          state_q    <= S_WRITE;
        end
        S_WRITE: begin
          if (g_con[CON_DIR_BIT]) begin
            sfr_bus.wr    <= 1'b1;
            sfr_bus.addr  <= pad_q[gch_q];
            sfr_bus.wdata <= rd_word;
          end else begin
            ram_bus.wr    <= 1'b1;
            ram_bus.addr  <= raddr_q;
            ram_bus.wdata <= rd_word;
            if (g_con[CON_NULL_BIT]) begin
              sfr_bus.wr    <= 1'b1;
              sfr_bus.addr  <= pad_q[gch_q];
              sfr_bus.wdata <= ZERO16;
            end
          end
          state_q <= S_DONE;
        end
        S_DONE: begin
          ram_bus.wr <= 1'b0;
          sfr_bus.wr <= 1'b0;
          state_q    <= S_IDLE;
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  apb_ready_a: assert property (@(posedge clk) disable iff (!nrst)
    psel && !penable |=> pready && !$past(penable)) else $error("slave not ready in access");
  prio_grant_a: assert property (@(posedge clk) disable iff (!nrst)
    state_q == S_IDLE && pend_q[0] |=> state_q == S_READ && gch_q == 3'h0)
    else $error("channel 0 lost arbitration");
  xfer_seq_a: assert property (@(posedge clk) disable iff (!nrst)
    state_q == S_IDLE && pend_q != '0 |=> (ram_bus.rd || sfr_bus.rd) ##1
    !(ram_bus.rd || sfr_bus.rd) ##1 (ram_bus.wr || sfr_bus.wr)) else $error("bad transfer order");
  dir_read_a: assert property (@(posedge clk) disable iff (!nrst)
    state_q == S_READ |-> (ram_bus.rd == g_con[CON_DIR_BIT]) && (sfr_bus.rd != ram_bus.rd))
    else $error("read on wrong bus");
  null_wr_a: assert property (@(posedge clk) disable iff (!nrst)
    ram_bus.wr && g_con[CON_NULL_BIT] |-> sfr_bus.wr && sfr_bus.wdata == ZERO16)
    else $error("missing null write");
  oneshot_off_a: assert property (@(posedge clk) disable iff (!nrst)
    state_q == S_DONE && g_con[MODE_OS_BIT] && tally_q[gch_q] == cnt_q[gch_q]
    && !(wr_acc && is_chan) |=> !con_q[$past(gch_q)][CON_ON_BIT]) else $error("one-shot still on");
  force_clr_a: assert property (@(posedge clk) disable iff (!nrst)
    state_q == S_DONE && gforce_q && !(wr_acc && is_chan) |=> !force_q[$past(gch_q)])
    else $error("force not cleared");
  irq_full_a: assert property (@(posedge clk) disable iff (!nrst)
    state_q == S_DONE && !g_con[CON_HALF_BIT] && tally_q[gch_q] == cnt_q[gch_q]
    |=> chan_irq[$past(gch_q)]) else $error("no block interrupt");
  clash_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    (xclash_q & ~$past(xclash_q)) != '0 |-> $past(state_q) == S_DONE
    && (xclash_q & ~$past(xclash_q)) == (NCH'(1) << $past(gch_q)))
    else $error("clash flag set without clash");

endmodule // edma_top
